//--- uarx_pkg.sv
/*
  Package for the asynchronous receive recovery block: frame sizes,
  sample counts, voting positions and the frame result carrier.
  Assumes a single system clock and a sample tick from an outside divider.
*/
package uarx_pkg;

  // ************************************************************
  // Sampling figures
  // ************************************************************
  localparam logic [4:0] samples_normal  = 5'h10;
  localparam logic [4:0] samples_double  = 5'h08;
  localparam logic [4:0] vote_first_norm = 5'h08;
  localparam logic [4:0] vote_first_dbl  = 5'h04;
  localparam logic [3:0] min_data_bits   = 4'h5;
  localparam logic [3:0] max_data_bits   = 4'ha;
  localparam logic [1:0] sync_reset      = 2'h3;

  // ************************************************************
  // Receiver states and result carrier
  // ************************************************************
  typedef enum logic [2:0]
  {
    st_idle  = 3'b001,
    st_start = 3'b010,
    st_data  = 3'b100
  } uarx_state_type;

  typedef struct packed
  {
    logic [9:0] data;
    logic       frame_error;
  } uarx_frame_type;

endpackage

//--- uarx_recovery.sv
/*
  Receive clock and data recovery front end of an asynchronous serial port.
  Assumes sample_tick pulses one mclk cycle at 16x (or 8x in double speed)
  the baud rate, and that the receive buffer takes each frame_valid pulse.
*/
// Behaviour
// - Sample at 16x, or 8x in double speed.
// - Falling edge starts qualification, first low is one.
// - Vote samples 8,9,10 or 4,5,6 for start.
// - Majority high start is noise; resume waiting.
// - Resynchronise sample phase on each accepted start.
// - Sixteen or eight sample states per bit.
// - Data bits take majority of centre samples.
// - Stop after first stop bit; ignore others.
// - Stop bit voted; zero sets frame error.
// - New start accepted right after stop vote.
// - Frames carry five to ten data bits.
// - Frame error travels with its frame.
module uarx_recovery
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    sample_tick,
  input  wire logic                    double_speed_select,
  input  wire logic [3:0]              data_bits,
  input  wire logic                    serial_rx_pin,
  output      logic                    frame_valid,
  output      uarx_pkg::uarx_frame_type frame_out,
  output      logic                    frame_error_flag,
  output      logic                    busy
);

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  logic [1:0] sync_chain;
  logic       line_prev;

  // Stage one is read only by stage two, so metastability cannot spread.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync_chain <= uarx_pkg::sync_reset;
    end
    else
    begin
      sync_chain <= {sync_chain[0], serial_rx_pin};
    end
  end

  wire line_s = sync_chain[1];

  // ************************************************************
  // Mode decode
  // ************************************************************
  uarx_pkg::uarx_state_type state;
  uarx_pkg::uarx_state_type next_state;
  logic [4:0] sample_num;
  logic [3:0] bit_idx;
  logic [1:0] high_votes;
  logic [9:0] shift_data;

  // Out of range sizes are clamped so a frame always ends.
  wire [3:0] size_lo  = (data_bits < uarx_pkg::min_data_bits) ? uarx_pkg::min_data_bits
                                                              : data_bits;
  wire [3:0] size_eff = (size_lo > uarx_pkg::max_data_bits) ? uarx_pkg::max_data_bits
                                                            : size_lo;
  wire [4:0] per_bit  = double_speed_select ? uarx_pkg::samples_double
                                            : uarx_pkg::samples_normal;
  wire [4:0] vote_lo  = double_speed_select ? uarx_pkg::vote_first_dbl
                                            : uarx_pkg::vote_first_norm;
  wire [4:0] vote_hi  = vote_lo + 5'h02;
  wire       in_vote  = (sample_num >= vote_lo) && (sample_num <= vote_hi);
  wire       vote_end = sample_num == vote_hi;
  wire [1:0] votes    = high_votes + {1'b0, line_s};
  wire       majority = votes[1];
  wire       fall     = line_prev && !line_s;
  wire       is_stop  = bit_idx == size_eff;
  wire       bit_done = sample_tick && vote_end;

  // Next state: start is voted at the centre, data and stop likewise.
  always_comb
  begin
    next_state = state;
    case (state)
      uarx_pkg::st_idle:
        if (sample_tick && fall)
          next_state = uarx_pkg::st_start;
      uarx_pkg::st_start:
        if (bit_done)
          next_state = majority ? uarx_pkg::st_idle : uarx_pkg::st_data;
      uarx_pkg::st_data:
        if (bit_done && is_stop)
          next_state = uarx_pkg::st_idle;
      default:
        next_state = uarx_pkg::st_idle;
    endcase
  end

  // ************************************************************
  // Sample counter, voting and shifting
  // ************************************************************
  // The edge detector watches only on ticks; idle line is taken as high.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      line_prev <= 1'b1;
    end
    else if (sample_tick)
    begin
      line_prev <= line_s;
    end
  end

  // The counter loads two on each idle tick, so the first low sample of each frame counts as one.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state      <= uarx_pkg::st_idle;
      sample_num <= 5'h00;
      bit_idx    <= 4'h0;
      high_votes <= 2'h0;
    end
    else
    begin
      state <= next_state;
      if (sample_tick)
      begin
        if (state == uarx_pkg::st_idle)
        begin
          sample_num <= 5'h02;
          bit_idx    <= 4'h0;
          high_votes <= 2'h0;
        end
        else if (bit_done)
        begin
          // The count carries on with the sample after the last vote, so each bit
          // keeps its full length and the next bit starts at sample one.
          sample_num <= vote_hi + 5'h01;
          high_votes <= 2'h0;
          if (state == uarx_pkg::st_data)
            bit_idx <= bit_idx + 4'h1;
        end
        else
        begin
          sample_num <= (sample_num == per_bit) ? 5'h01 : sample_num + 5'h01;
          if (in_vote)
            high_votes <= votes;
        end
      end
    end
  end

  // Data shifts LSB first into the top, then is aligned on output.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      shift_data <= 10'h000;
    end
    else if (bit_done && state == uarx_pkg::st_data && !is_stop)
    begin
      shift_data <= {majority, shift_data[9:1]};
    end
  end

  wire [9:0] aligned = shift_data >> (uarx_pkg::max_data_bits - size_eff);

  // ************************************************************
  // Frame result
  // ************************************************************
  // The error flag is held with the frame so the buffer stores them together.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      frame_valid      <= 1'b0;
      frame_out        <= '0;
      frame_error_flag <= 1'b0;
      busy             <= 1'b0;
    end
    else
    begin
      frame_valid <= bit_done && state == uarx_pkg::st_data && is_stop;
      busy        <= next_state != uarx_pkg::st_idle;
      if (bit_done && state == uarx_pkg::st_data && is_stop)
      begin
        frame_out.data        <= aligned;
        frame_out.frame_error <= !majority;
        frame_error_flag      <= !majority;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  stop_error_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (bit_done && state == uarx_pkg::st_data && is_stop) |=> frame_error_flag == !$past(majority))
    else $error("frame error does not follow stop vote");
  noise_reject_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (bit_done && state == uarx_pkg::st_start && majority) |=> state == uarx_pkg::st_idle)
    else $error("noisy start not rejected");
  start_accept_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (bit_done && state == uarx_pkg::st_start && !majority) |=> state == uarx_pkg::st_data)
    else $error("valid start not accepted");
  first_sample_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (sample_tick && state == uarx_pkg::st_idle && fall) |=> sample_num == 5'h02)
    else $error("first low sample not counted as one");
  count_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sample_num <= uarx_pkg::samples_normal)
    else $error("sample counter out of range");
  pulse_once_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_valid |=> !frame_valid)
    else $error("frame valid longer than one cycle");
  frame_carry_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_valid |-> frame_out.frame_error == frame_error_flag)
    else $error("frame error not stored with frame");
  idle_after_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_valid |-> state == uarx_pkg::st_idle)
    else $error("receiver not ready after stop vote");
  good_frame_c: cover property (@(posedge mclk) frame_valid && !frame_error_flag);
  bad_frame_c: cover property (@(posedge mclk) frame_valid && frame_error_flag);
  noise_c: cover property (@(posedge mclk)
    bit_done && state == uarx_pkg::st_start && majority);
  double_c: cover property (@(posedge mclk) frame_valid && double_speed_select);

endmodule

//--- uarx_tx_model.sv
/*
  Model of the remote asynchronous transmitter that drives the serial line.
  Assumes the bench calls its tasks at tick edges; sample_tick paces each bit.
*/
module uarx_tx_model
(
  input  wire logic mclk,
  input  wire logic sample_tick,
  output      logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line idles high, as its pull-up would hold it.
  initial line = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk iff sample_tick);
  endtask

  // Bit time is an exact count of ticks, so the rate error is zero.
  task automatic send(input logic [9:0] d, input int nb, input int sp,
                      input int stop_len, input logic stop_val);
    line <= 1'b0;
    ticks(sp);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      ticks(sp);
    end
    line <= stop_val;
    ticks(stop_len);
  endtask

  // A short low spike; it ends with the line back at idle.
  task automatic glitch(input int n);
    line <= 1'b0;
    ticks(n);
    line <= 1'b1;
  endtask

  task automatic idle();
    line <= 1'b1;
  endtask
endmodule

//--- uarx_recovery_tb_top.sv
/*
  Self-checking bench for the receive recovery front end.
  Assumes the transmitter model above and a tick every fourth mclk.
*/
module uarx_recovery_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     mclk, sys_rst, sample_tick, double_speed_select;
  logic                     serial_rx_pin, frame_valid, frame_error_flag, busy;
  logic [3:0]               data_bits;
  logic [1:0]               tick_cnt;
  uarx_pkg::uarx_frame_type frame_out;
  int                       error_cnt, n_tests;

  always #5 mclk = ~mclk;

  // A tick every fourth cycle keeps frames short yet leaves gaps between ticks.
  always @(posedge mclk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= (tick_cnt == 2'h3);
  end

  uarx_recovery u_dut (.mclk(mclk), .sys_rst(sys_rst), .sample_tick(sample_tick),
    .double_speed_select(double_speed_select), .data_bits(data_bits),
    .serial_rx_pin(serial_rx_pin), .frame_valid(frame_valid), .frame_out(frame_out),
    .frame_error_flag(frame_error_flag), .busy(busy));

  uarx_tx_model u_tx (.mclk(mclk), .sample_tick(sample_tick), .line(serial_rx_pin));

  // ************************************************************
  // Checking tasks
  // ************************************************************
  task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Waits a bounded time for one frame pulse and compares what it carries.
  task automatic recv(input logic [9:0] d, input int nb, input logic fe);
    int k;
    k = 0;
    while (frame_valid !== 1'b1 && k < 3000)
    begin
      @(posedge mclk);
      k++;
    end
    chk("valid", {10'h000, frame_valid}, 11'h001);
    chk("frame", frame_out, {d & ((10'h001 << nb) - 10'h001), fe});
    chk("flag", {10'h000, frame_error_flag}, {10'h000, fe});
    @(posedge mclk);
  endtask

  task automatic frame(input string name, input logic ds, input logic [3:0] nb,
                       input logic [9:0] d, input logic stop);
    int n;
    // The receiver clamps the size port, so the partner sends the clamped count.
    n = (nb < uarx_pkg::min_data_bits) ? int'(uarx_pkg::min_data_bits)
      : (nb > uarx_pkg::max_data_bits) ? int'(uarx_pkg::max_data_bits) : int'(nb);
    double_speed_select <= ds;
    data_bits <= nb;
    u_tx.ticks(2);
    fork
      u_tx.send(d, n, ds ? 8 : 16, ds ? 8 : 16, stop);
      recv(d, n, ~stop);
    join
    u_tx.idle();
    u_tx.ticks(40);
    $display("test %s done", name);
  endtask

  // A spike too short for the vote must leave no frame and an idle receiver.
  task automatic noise();
    int seen;
    seen = 0;
    u_tx.glitch(4);
    chk("qualify", {10'h000, busy}, 11'h001);
    // Long enough that a wrongly accepted start would finish its frame in view.
    repeat (600)
    begin
      @(posedge mclk);
      if (frame_valid === 1'b1) seen++;
    end
    chk("noise", 11'(seen), 11'h000);
    chk("idle", {10'h000, busy}, 11'h000);
    $display("test noise done");
  endtask

  // Second start comes straight after the first stop's last vote sample.
  task automatic b2b();
    data_bits <= 4'h5;
    u_tx.ticks(2);
    fork
      begin
        u_tx.send(10'h015, 5, 16, 10, 1'b1);
        u_tx.send(10'h00a, 5, 16, 16, 1'b1);
      end
      begin
        recv(10'h015, 5, 1'b0);
        recv(10'h00a, 5, 1'b0);
      end
    join
    u_tx.ticks(10);
    $display("test b2b done");
  endtask

  initial
  begin
    mclk = 1'b0;
    tick_cnt = 2'h0;
    sample_tick = 1'b0;
    sys_rst = 1'b1;
    double_speed_select = 1'b0;
    data_bits = 4'h8;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("reset", {8'h00, frame_valid, busy, frame_error_flag}, 11'h000);
    frame("norm8", 1'b0, 4'h8, 10'h0a5, 1'b1);
    frame("ferr", 1'b0, 4'h8, 10'h03c, 1'b0);
    frame("dbl10", 1'b1, 4'ha, 10'h2c3, 1'b1);
    frame("dbl5err", 1'b1, 4'h5, 10'h3f5, 1'b0);
    double_speed_select <= 1'b0;
    noise();
    frame("after", 1'b0, 4'h7, 10'h05a, 1'b1);
    frame("clamp", 1'b0, 4'hf, 10'h2b6, 1'b1);
    b2b();
    test_done();
  end

  initial
  begin
    #400000;
    error_cnt++;
    test_done();
  end
endmodule
